// ==== verilog/dspcs_pkg.sv ====
// Shared constants and types of the dual slot power control sequencer
package dspcs_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Standby must stay valid this long before the reset cycle starts
  localparam int unsigned STBY_VALID_US = 500;
  localparam int unsigned STBY_VALID_CYC =
    (STBY_VALID_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POR_CNT_W = 16;
  // Length of the register clearing phase
  localparam logic [3:0] CLEAR_CYC = 4'h4;
  localparam int unsigned NUM_SLOTS = 2;
  localparam int unsigned NUM_MAIN = 4;
  typedef enum logic {
    DSPCS_MODE_PIN,
    DSPCS_MODE_BUS
  } dspcs_mode_t;
endpackage

// ==== verilog/dspcs_slot.sv ====
// One slot: main and aux turn-on gating and breaker latch
`timescale 1ns/1ps
module dspcs_slot (
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic main_en,
  input wire logic main_en_edge,
  input wire logic aux_en,
  input wire logic inputs_ok,
  input wire logic trip,
  output logic main_on,
  output logic aux_on,
  output logic fault_set
);
  typedef struct packed {
    logic main_on;
    logic aux_on;
    logic tripped;
    logic fault_set;
  } dspcs_slot_st_t;

  dspcs_slot_st_t st_ff;
  dspcs_slot_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.fault_set = 1'b0;
    // Fresh enable edge re-arms after a breaker trip
    if (main_en_edge) begin
      nxt_st.tripped = 1'b0;
    end
    if (main_en && (trip || !inputs_ok) && st_ff.main_on) begin
      nxt_st.tripped = 1'b1;
      nxt_st.fault_set = 1'b1;
    end
    nxt_st.main_on = run && main_en && inputs_ok
      && !nxt_st.tripped && !trip;
    nxt_st.aux_on = run && aux_en;
    if (!run) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign main_on = st_ff.main_on;
  assign aux_on = st_ff.aux_on;
  assign fault_set = st_ff.fault_set;
endmodule

// ==== verilog/dspcs_top.sv ====
// Top of the dual slot power control sequencer
`timescale 1ns/1ps
module dspcs_top (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Standby status and power control mode
  input wire logic standby_supply_ok,
  input wire logic bus_power_mode,
  // Pin interface enables
  input wire logic slot0_main_enable_in,
  input wire logic slot1_main_enable_in,
  input wire logic slot0_aux_enable_in,
  input wire logic slot1_aux_enable_in,
  // Management bus side controls
  input wire logic [1:0] ctrl_main_bits,
  input wire logic [1:0] ctrl_aux_bits,
  input wire logic ctrl_write,
  input wire logic [1:0] fault_clear_wr,
  input wire logic int_mask,
  // Main supply and breaker status
  input wire logic [7:0] supply_ok,
  input wire logic [1:0] breaker_trip,
  // Sequencer status and slot drives
  output logic bus_ready,
  output logic regs_clear,
  output logic [1:0] slot_main_on,
  output logic [1:0] slot_aux_on,
  output logic [1:0] gate_drive_en,
  output logic [1:0] discharge_en,
  output logic [1:0] slot_fault_n,
  output logic int_n,
  output logic [1:0] fault_status
);
  typedef enum logic [1:0] {
    ST_WAIT,
    ST_CLEAR,
    ST_RUN
  } dspcs_state_t;

  typedef struct packed {
    // Sequencer phase and its shared timer
    dspcs_state_t state;
    logic [dspcs_pkg::POR_CNT_W-1:0] cnt;
    // Pin history, host controls and fault memory
    logic [1:0] pin_main_d;
    logic [1:0] ctrl_main;
    logic [1:0] ctrl_aux;
    logic [1:0] fstat;
    logic [1:0] pin_fault;
    // Registered outputs
    logic bus_ready;
    logic regs_clear;
    logic [1:0] main_on;
    logic [1:0] aux_on;
    logic [1:0] gate;
    logic [1:0] dis;
    logic [1:0] fault_n;
    logic int_n;
  } dspcs_st_t;

  dspcs_st_t st_ff;
  dspcs_st_t nxt_st;
  // Enable paths between the mode select and the slot cores
  logic [1:0] pin_main;
  logic [1:0] pin_aux;
  logic [1:0] eff_main;
  logic [1:0] eff_aux;
  logic [1:0] main_edge;
  logic [1:0] core_main;
  logic [1:0] core_aux;
  logic [1:0] core_fault;
  logic run;
  logic bus_mode;

  assign pin_main = {slot1_main_enable_in, slot0_main_enable_in};
  assign pin_aux = {slot1_aux_enable_in, slot0_aux_enable_in};
  assign run = (st_ff.state == ST_RUN);
  assign bus_mode = bus_power_mode;

  // Enable source follows the mode; the idle source is ignored
  always_comb begin
    if (bus_mode) begin
      eff_main = st_ff.ctrl_main;
      eff_aux = st_ff.ctrl_aux;
      main_edge = {2{ctrl_write && run}} & ctrl_main_bits;
    end else begin
      eff_main = pin_main;
      eff_aux = pin_aux;
      main_edge = pin_main & ~st_ff.pin_main_d;
    end
  end

  // One core per slot
  genvar gi;
  generate
    for (gi = 0; gi < dspcs_pkg::NUM_SLOTS; gi++) begin : g_slot
      dspcs_slot i_dspcs_slot (
        .clk(clk),
        .srst(srst),
        .run(run),
        .main_en(eff_main[gi]),
        .main_en_edge(main_edge[gi]),
        .aux_en(eff_aux[gi]),
        .inputs_ok(&supply_ok[gi*dspcs_pkg::NUM_MAIN +:
          dspcs_pkg::NUM_MAIN]),
        .trip(breaker_trip[gi]),
        .main_on(core_main[gi]),
        .aux_on(core_aux[gi]),
        .fault_set(core_fault[gi])
      );
    end
  endgenerate

  always_comb begin
    nxt_st = st_ff;
    nxt_st.regs_clear = 1'b0;
    nxt_st.pin_main_d = pin_main;
    case (st_ff.state)
      ST_WAIT: begin
        // Standby must hold without a break for the whole window
        if (!standby_supply_ok) begin
          nxt_st.cnt = '0;
        end else if (st_ff.cnt ==
            dspcs_pkg::POR_CNT_W'(dspcs_pkg::STBY_VALID_CYC - 1)) begin
          nxt_st.cnt = '0;
          nxt_st.state = ST_CLEAR;
        end else begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
      ST_CLEAR: begin
        // Wipe host controls and fault memory
        nxt_st.regs_clear = 1'b1;
        nxt_st.ctrl_main = '0;
        nxt_st.ctrl_aux = '0;
        nxt_st.fstat = '0;
        nxt_st.pin_fault = '0;
        if (st_ff.cnt[3:0] == dspcs_pkg::CLEAR_CYC - 4'h1) begin
          nxt_st.cnt = '0;
          nxt_st.state = ST_RUN;
        end else begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
      ST_RUN: begin
        // Control bits load only in bus mode
        if (ctrl_write && bus_mode) begin
          nxt_st.ctrl_main = ctrl_main_bits;
          nxt_st.ctrl_aux = ctrl_aux_bits;
        end
        // Write-one clears; a new fault in the same cycle wins
        nxt_st.fstat = (st_ff.fstat & ~fault_clear_wr)
          | core_fault;
        nxt_st.pin_fault = (st_ff.pin_fault & ~main_edge)
          | (core_fault & {2{!bus_mode}});
      end
      default: begin
        nxt_st.state = ST_WAIT;
        nxt_st.cnt = '0;
      end
    endcase
    // Any standby dropout restarts the whole sequence
    if (!standby_supply_ok) begin
      nxt_st = '0;
      nxt_st.state = ST_WAIT;
      nxt_st.pin_main_d = pin_main;
    end
    nxt_st.bus_ready = (nxt_st.state == ST_RUN);
    // Slot drives stay off outside the run phase, also while the slot
    // cores still hold their last state just after a standby dropout
    if (nxt_st.bus_ready) begin
      nxt_st.main_on = core_main;
      nxt_st.aux_on = core_aux;
      nxt_st.gate = core_main;
      nxt_st.dis = ~core_main;
    end else begin
      nxt_st.main_on = '0;
      nxt_st.aux_on = '0;
      nxt_st.gate = '0;
      nxt_st.dis = '1;
    end
    // The fault pin reports only faults of pin-enabled slots
    nxt_st.fault_n = ~nxt_st.pin_fault;
    // Interrupt follows pending status unless masked
    nxt_st.int_n = !((|nxt_st.fstat) && !int_mask);
  end

  // Reset leaves the slots off with their discharge switches closed
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.state <= ST_WAIT;
      st_ff.fault_n <= '1;
      st_ff.int_n <= 1'b1;
      st_ff.dis <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Every output is a register bit
  assign bus_ready = st_ff.bus_ready;
  assign regs_clear = st_ff.regs_clear;
  assign slot_main_on = st_ff.main_on;
  assign slot_aux_on = st_ff.aux_on;
  assign gate_drive_en = st_ff.gate;
  assign discharge_en = st_ff.dis;
  assign slot_fault_n = st_ff.fault_n;
  assign int_n = st_ff.int_n;
  assign fault_status = st_ff.fstat;
endmodule

// ==== testbench/dspcs_host_model.sv ====
// Host side model: pin enables and bus control writes
`timescale 1ns/1ps
module dspcs_host_model (
  input wire logic bus_mode,
  input wire logic [1:0] want_main,
  input wire logic [1:0] want_aux,
  input wire logic want_write,
  output logic [1:0] pin_main,
  output logic [1:0] pin_aux,
  output logic ctrl_write
);
  assign pin_main = bus_mode ? 2'h0 : want_main;
  assign pin_aux = bus_mode ? 2'h0 : want_aux;
  assign ctrl_write = bus_mode & want_write;
endmodule

// ==== testbench/dspcs_monitor.sv ====
// Assertion checker of the sequencer ports
`timescale 1ns/1ps
module dspcs_monitor (
  input wire logic clk,
  input wire logic srst,
  input wire logic standby_supply_ok,
  input wire logic [7:0] supply_ok,
  input wire logic bus_ready,
  input wire logic regs_clear,
  input wire logic [1:0] slot_main_on,
  input wire logic [1:0] slot_aux_on,
  input wire logic [1:0] gate_drive_en,
  input wire logic [1:0] discharge_en,
  input wire logic int_n,
  input wire logic [1:0] fault_status
);
  logic [16:0] stby_cnt_ff;
  logic [16:0] nxt_stby_cnt;
  always_comb begin
    nxt_stby_cnt = stby_cnt_ff;
    if (!standby_supply_ok) nxt_stby_cnt = 17'h0;
    else if (stby_cnt_ff != 17'h1FFFF) nxt_stby_cnt = stby_cnt_ff + 17'h1;
  end
  always_ff @(posedge clk) begin
    stby_cnt_ff <= srst ? 17'h0 : nxt_stby_cnt;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  chk_ready_after_stby: assert property (bus_ready |->
    stby_cnt_ff >= dspcs_pkg::STBY_VALID_CYC) else $error("ready early");
  chk_clear_then_ready: assert property ($rose(bus_ready) |->
    $past(regs_clear)) else $error("no clear phase");
  chk_off_in_reset: assert property (!bus_ready |->
    slot_main_on == 2'h0 && slot_aux_on == 2'h0) else $error("on in reset");
  chk_stby_drop: assert property (!standby_supply_ok |=>
    !bus_ready) else $error("ready after drop");
  chk_gate_low_off: assert property (
    gate_drive_en == slot_main_on) else $error("gate while off");
  chk_discharge_off: assert property (
    (~(slot_main_on | slot_aux_on) & ~discharge_en) == 2'h0)
    else $error("no discharge");
  chk_main_supply: assert property ($rose(slot_main_on[0]) |->
    $past(supply_ok[3:0], 2) == 4'hF) else $error("on with undervoltage");
  chk_slot1_supply: assert property ($rose(slot_main_on[1]) |->
    $past(supply_ok[7:4], 2) == 4'hF) else $error("on with undervoltage");
  chk_int_cause: assert property (!int_n |->
    fault_status != 2'h0) else $error("interrupt without fault");
endmodule
bind dspcs_top dspcs_monitor i_dspcs_monitor (.clk, .srst,
  .standby_supply_ok, .supply_ok, .bus_ready, .regs_clear, .slot_main_on,
  .slot_aux_on, .gate_drive_en, .discharge_en, .int_n, .fault_status);

// ==== testbench/testbench.sv ====
// Self-checking bench of the sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  $display("MISMATCH %s exp %h got %h", nm, e, g); fails++; end end
module testbench;
  logic clk = 1'b0, srst = 1'b1, stby = 1'b0, bmode = 1'b0, wwr = 1'b0;
  logic imask = 1'b0, cw, bus_ready, regs_clear, int_n;
  logic [1:0] wmain = 2'h0, waux = 2'h0, cmain = 2'h0, caux = 2'h0;
  logic [1:0] fclr = 2'h0, trip = 2'h0, pmain, paux;
  logic [1:0] main_on, aux_on, gate, dis, fault_n, fstat;
  logic [7:0] sok = 8'h0F;
  int fails = 0, tests_run = 0, cyc = 0;
  always #5 clk = ~clk;
  dspcs_host_model i_dspcs_host_model (.bus_mode(bmode), .want_main(wmain),
    .want_aux(waux), .want_write(wwr), .pin_main(pmain), .pin_aux(paux),
    .ctrl_write(cw));
  dspcs_top i_dspcs_top (.clk(clk), .srst(srst), .standby_supply_ok(stby),
    .bus_power_mode(bmode), .slot0_main_enable_in(pmain[0]),
    .slot1_main_enable_in(pmain[1]), .slot0_aux_enable_in(paux[0]),
    .slot1_aux_enable_in(paux[1]), .ctrl_main_bits(cmain),
    .ctrl_aux_bits(caux), .ctrl_write(cw), .fault_clear_wr(fclr),
    .int_mask(imask), .supply_ok(sok), .breaker_trip(trip),
    .bus_ready(bus_ready), .regs_clear(regs_clear), .slot_main_on(main_on),
    .slot_aux_on(aux_on), .gate_drive_en(gate), .discharge_en(dis),
    .slot_fault_n(fault_n), .int_n(int_n), .fault_status(fstat));
  task automatic tally_and_finish();
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 101000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic t_por();
    tick(dspcs_pkg::STBY_VALID_CYC - 10);
    `CHK("ready", 1'b0, bus_ready)
    `CHK("main", 2'h0, main_on)
    for (int k = 0; k < 60000 && bus_ready !== 1'b1; k++) tick(1);
    `CHK("ready", 1'b1, bus_ready)
  endtask
  task automatic t_pin();
    tick(3);
    `CHK("main", 2'h1, main_on)
    `CHK("gate", 2'h1, gate)
    `CHK("dis", 2'h2, dis)
  endtask
  task automatic t_trip();
    trip = 2'h1;
    tick(1);
    trip = 2'h0;
    tick(3);
    `CHK("main", 2'h0, main_on)
    `CHK("fstat", 2'h1, fstat)
    `CHK("int", 1'b0, int_n)
    `CHK("fault", 2'h2, fault_n)
    imask = 1'b1;
    tick(1);
    `CHK("int", 1'b1, int_n)
    imask = 1'b0;
    tick(1);
    `CHK("int", 1'b0, int_n)
    fclr = 2'h1;
    tick(1);
    fclr = 2'h0;
    tick(2);
    `CHK("int", 1'b1, int_n)
    wmain = 2'h2;
    tick(2);
    wmain = 2'h3;
    tick(3);
    `CHK("main", 2'h1, main_on)
    `CHK("fault", 2'h3, fault_n)
  endtask
  task automatic t_bus();
    bmode = 1'b1;
    tick(3);
    `CHK("main", 2'h0, main_on)
    sok = 8'hFF;
    cmain = 2'h2;
    caux = 2'h1;
    wwr = 1'b1;
    tick(1);
    wwr = 1'b0;
    tick(3);
    `CHK("main", 2'h2, main_on)
    `CHK("aux", 2'h1, aux_on)
    trip = 2'h2;
    tick(1);
    trip = 2'h0;
    tick(3);
    `CHK("main", 2'h0, main_on)
    `CHK("fstat", 2'h2, fstat)
    `CHK("fault", 2'h3, fault_n)
    wwr = 1'b1;
    tick(1);
    wwr = 1'b0;
    tick(3);
    `CHK("main", 2'h2, main_on)
  endtask
  task automatic t_drop();
    stby = 1'b0;
    tick(2);
    `CHK("ready", 1'b0, bus_ready)
    `CHK("aux", 2'h0, aux_on)
    `CHK("main", 2'h0, main_on)
    `CHK("dis", 2'h3, dis)
    stby = 1'b1;
    t_por();
    `CHK("main", 2'h0, main_on)
    `CHK("fstat", 2'h0, fstat)
  endtask
  initial begin
    wmain = 2'h3;
    tick(20);
    srst = 1'b0;
    stby = 1'b1;
    t_por();
    t_pin();
    t_trip();
    t_bus();
    t_drop();
    tally_and_finish();
  end
endmodule
